//--- logic/mdpcb_pkg.sv
// constants for the memory decode and power management configuration bank
package mdpcb_pkg;
    // register offsets in configuration space
    localparam logic [7:0] E_SEGMENT_SHADOW_CTRL         = 8'h54;
    localparam logic [7:0] D_SEGMENT_SHADOW_CTRL         = 8'h55;
    localparam logic [7:0] C_SEGMENT_SHADOW_CTRL         = 8'h56;
    localparam logic [7:0] UNCACHED_AREA1_CTRL           = 8'h57;
    localparam logic [7:0] UNCACHED_AREA1_BASE_LOW       = 8'h58;
    localparam logic [7:0] UNCACHED_AREA2_CTRL           = 8'h59;
    localparam logic [7:0] UNCACHED_AREA2_BASE_LOW       = 8'h5a;
    localparam logic [7:0] LEGACY_EMULATION_REFRESH_CTRL = 8'h5b;
    localparam logic [7:0] POST_WRITE_LATENCY_MISC_CTRL  = 8'h5c;
    localparam logic [7:0] PCI_BRIDGE_CTRL               = 8'h5d;
    localparam logic [7:0] SYSTEM_STANDBY_EVENT_MASK     = 8'h5e;
    localparam logic [7:0] MONITOR_WAKE_EVENT_MASK       = 8'h5f;
    localparam int         NUM_REGS                      = 12;
    localparam logic [7:0] REG_RESET                     = 8'h00;
    // field positions
    localparam int NC_ALLOC_BIT = 7, NC_EN_BIT = 6, NC_SIZE_LSB = 3;
    localparam int A20_EN_BIT = 7, FRST_EN_BIT = 6, FRST_LAT_BIT = 5;
    localparam int SLOW_RFSH_BIT = 4, DT_HOLD_BIT = 2, DT_SW_BIT = 1;
    localparam int ADS_LAT_BIT = 7, RFSH_HOLD_BIT = 6, SNOOP_BIT = 5;
    localparam int FULL_LAT_BIT = 3, PARITY_DIS_BIT = 0;
    localparam int PCLK_SEL_LSB = 6, BURST_RANGE_BIT = 5, TRDY_LAT_BIT = 2;
    localparam int PCI_BURST_BIT = 1, PCI_POST_BIT = 0;
    // keyboard controller emulation codes
    localparam logic [15:0] KBC_CMD_PORT   = 16'h0064;
    localparam logic [15:0] KBC_DATA_PORT  = 16'h0060;
    localparam logic [7:0]  A20_CMD        = 8'hd1;
    localparam logic [7:0]  A20_MASK_DATA  = 8'h00;
    localparam logic [3:0]  FRST_CMD_HIGH  = 4'hf;
    // timing
    localparam int CLK_MHZ        = 200;
    localparam int FRST_SHORT_NS  = 2000;
    localparam int FRST_LONG_NS   = 6000;
    localparam int RST_HOLD_CLKS  = 25;
    localparam int DT_SHORT_NS    = 4000;
    localparam int DT_LONG_NS     = 8000;
    localparam int DT_PERIOD_NS   = 12000;
    localparam int FRST_SHORT_CLK = FRST_SHORT_NS * CLK_MHZ / 1000;
    localparam int FRST_LONG_CLK  = FRST_LONG_NS * CLK_MHZ / 1000;
    localparam int DT_SHORT_CLK   = DT_SHORT_NS * CLK_MHZ / 1000;
    localparam int DT_LONG_CLK    = DT_LONG_NS * CLK_MHZ / 1000;
    localparam int DT_PERIOD_CLK  = DT_PERIOD_NS * CLK_MHZ / 1000;
    // pci clock enable: phase accumulator over PCLK_MOD (3x clock rate)
    localparam logic [9:0] PCLK_MOD = 10'd600, PCLK_INC_DIV2 = 10'd300;
    localparam logic [9:0] PCLK_INC_DIV15 = 10'd400, PCLK_INC_14M = 10'd42;
    localparam logic [10:0] BURST_512 = 11'd512, BURST_1K = 11'd1024;
endpackage

//--- logic/mdpcb_bank.sv
// configuration bank with decode, legacy emulation, timing and standby event logic
`timescale 1ns/1ps
`default_nettype none
// How it works
// - push rate X-1-1-1 unless bit set
// - per-16KB shadow enable and cacheable bits
// - area 1 enable and expansion routing
// - area size doubles 64KB to 8MB
// - area base from A26-A16 fields
// - second identical independent non-cacheable area
// - A20 sequence claimed with slow devsel
// - fast reset after 2/6us, held 25 clocks
// - slow refresh at quarter rate
// - de-turbo hold 4us or 8 of 12us
// - switch enable off means always turbo
// - sample local status 3T or 2T
// - refresh in hold, snoop filter gated
// - burst ready 1T/2T after full clears
// - parity check active when bit clear
// - pci clock ratio select
// - pci burst range 512B or 1KB
// - burst ready 2/3 clocks after target ready
// - cpu to pci posting and bursting enables
// - enabled events reload system standby timer
// - monitor timer reload and wake events
// - enabled events release stop clock
module mdpcb_bank (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  cfg_addr,          // configuration register index
    input  wire logic        cfg_wr,            // write strobe
    input  wire logic        cfg_rd,            // read strobe
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata,         // valid the cycle after cfg_rd
    input  wire logic [31:0] host_addr,         // current host memory address
    output logic             shadow_hit,
    output logic             shadow_cacheable,
    output logic             uncached_hit,
    output logic             local_dram_off,    // area routed to expansion bus
    input  wire logic        push_rate_sel,     // push-rate select bit
    input  wire logic [1:0]  cache_burst_setting,
    output logic      [1:0]  post_push_rate,    // 0 means X-1-1-1
    input  wire logic        io_wr,             // host i/o write pulse
    input  wire logic        io_access,         // host i/o read or write pulse
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic             devsel_slow,       // claim with slowest devsel
    output logic             addr20_mask_n,
    output logic             processor_reset,
    input  wire logic        refresh_tick,      // normal refresh rate pulse
    input  wire logic        cpu_held,
    output logic             refresh_req,
    output logic             snoop_filter_en,
    input  wire logic        deturbo_switch,
    output logic             cpu_hold_req,
    input  wire logic        address_strobe_n,
    output logic             local_status_sample,
    input  wire logic        trdy_seen,         // pci target ready pulse
    input  wire logic        full_released,     // post buffer left full
    output logic             burst_ready_n,
    output logic             parity_check_en,
    output logic             pci_clock_en,      // pci_bus_clock rate enable
    output logic      [10:0] burst_limit_bytes,
    output logic             pci_post_en,
    output logic             pci_burst_en,
    input  wire logic        prog10_hit,
    input  wire logic        prog16_hit,
    input  wire logic        hold_event,
    input  wire logic        irq_event,
    input  wire logic        processor_init,
    input  wire logic        stop_clock_set,    // request to assert stop clock
    output logic             sys_standby_reload,
    output logic             monitor_reload,
    output logic             monitor_wake,
    output logic             stop_clock_n
);
    localparam int BASE = int'(mdpcb_pkg::E_SEGMENT_SHADOW_CTRL); // index of first register
    typedef enum logic [1:0] {MDPCB_IDLE, MDPCB_DELAY, MDPCB_ASSERT} mdpcb_frst_e;

    logic [7:0]  regs_q [mdpcb_pkg::NUM_REGS];   // register storage
    logic [7:0]  idx;                            // offset from first register
    logic        in_range;
    logic [7:0]  r5b, r5c, r5d, r5e, r5f;        // named views of control bytes

    assign idx      = cfg_addr - mdpcb_pkg::E_SEGMENT_SHADOW_CTRL;
    assign in_range = cfg_addr >= mdpcb_pkg::E_SEGMENT_SHADOW_CTRL &&
                      cfg_addr <= mdpcb_pkg::MONITOR_WAKE_EVENT_MASK;
    assign r5b = regs_q[mdpcb_pkg::LEGACY_EMULATION_REFRESH_CTRL - BASE];
    assign r5c = regs_q[mdpcb_pkg::POST_WRITE_LATENCY_MISC_CTRL - BASE];
    assign r5d = regs_q[mdpcb_pkg::PCI_BRIDGE_CTRL - BASE];
    assign r5e = regs_q[mdpcb_pkg::SYSTEM_STANDBY_EVENT_MASK - BASE];
    assign r5f = regs_q[mdpcb_pkg::MONITOR_WAKE_EVENT_MASK - BASE];

    // register writes; all bits clear so features start disabled, except parity checking which is on while its bit is clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < mdpcb_pkg::NUM_REGS; i++) begin
                regs_q[i] <= mdpcb_pkg::REG_RESET;
            end
        end else if (cfg_wr && in_range) begin
            regs_q[idx[3:0]] <= cfg_wdata;
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd) begin
            cfg_rdata <= in_range ? regs_q[idx[3:0]] : 8'h00;
        end
    end

    // shadow decode for c, d and e segments
    logic [7:0] seg_byte;
    logic       seg_hit;
    logic [1:0] sub;
    always_comb begin
        seg_hit  = 1'b1;
        unique case (host_addr[31:16])
            16'h000e: seg_byte = regs_q[0];
            16'h000d: seg_byte = regs_q[1];
            16'h000c: seg_byte = regs_q[2];
            default: begin
                seg_byte = 8'h00;
                seg_hit  = 1'b0;
            end
        endcase
        sub = host_addr[15:14];
    end

    // two non-cacheable areas, identical structure
    logic [1:0] nc_hit, nc_ext;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_area
            logic [7:0]  ctl, lo;
            logic [10:0] base, mask;
            assign ctl  = regs_q[3 + 2 * g];
            assign lo   = regs_q[4 + 2 * g];
            assign base = {ctl[2:0], lo};
            assign mask = 11'((11'h001 << ctl[5:3]) - 11'h001);
            // area sits in the first 128MB, so A31..A27 must be zero
            assign nc_hit[g] = ctl[mdpcb_pkg::NC_EN_BIT] &&
                               host_addr[31:27] == 5'h00 &&
                               ((host_addr[26:16] ^ base) & ~mask) == 11'h000;
            assign nc_ext[g] = nc_hit[g] & ctl[mdpcb_pkg::NC_ALLOC_BIT];
        end
    endgenerate

    // registered decode results; lowest sub-block owns the top shadow bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shadow_hit       <= 1'b0;
            shadow_cacheable <= 1'b0;
            uncached_hit     <= 1'b0;
            local_dram_off   <= 1'b0;
        end else begin
            shadow_hit       <= seg_hit & seg_byte[3'd7 - {1'b0, sub}];
            shadow_cacheable <= seg_hit & seg_byte[3'd3 - {1'b0, sub}];
            uncached_hit     <= |nc_hit;
            local_dram_off   <= |nc_ext;
        end
    end

    // static control outputs, registered from the bank; push rate registered from push_rate_sel and cache_burst_setting
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            post_push_rate    <= 2'b00;
            snoop_filter_en   <= 1'b0;
            parity_check_en   <= 1'b0;
            burst_limit_bytes <= mdpcb_pkg::BURST_512;
            pci_post_en       <= 1'b0;
            pci_burst_en      <= 1'b0;
        end else begin
            post_push_rate    <= push_rate_sel ? cache_burst_setting : 2'b00;
            snoop_filter_en   <= r5c[mdpcb_pkg::SNOOP_BIT];
            parity_check_en   <= ~r5c[mdpcb_pkg::PARITY_DIS_BIT];
            burst_limit_bytes <= r5d[mdpcb_pkg::BURST_RANGE_BIT] ?
                                 mdpcb_pkg::BURST_1K : mdpcb_pkg::BURST_512;
            pci_post_en       <= r5d[mdpcb_pkg::PCI_POST_BIT];
            pci_burst_en      <= r5d[mdpcb_pkg::PCI_BURST_BIT];
        end
    end

    // keyboard controller snoop
    logic wr64, wr60, a20_armed;
    assign wr64 = io_wr && io_addr == mdpcb_pkg::KBC_CMD_PORT;
    assign wr60 = io_wr && io_addr == mdpcb_pkg::KBC_DATA_PORT;

    // gate A20 emulation; claimed only when enabled, else left to subtractive decode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            devsel_slow   <= 1'b0;
            a20_armed     <= 1'b0;
            addr20_mask_n <= 1'b1;
        end else begin
            devsel_slow <= r5b[mdpcb_pkg::A20_EN_BIT] & (wr64 | wr60);
            if (!r5b[mdpcb_pkg::A20_EN_BIT]) begin
                a20_armed <= 1'b0;
            end else if (wr64) begin
                a20_armed <= io_wdata == mdpcb_pkg::A20_CMD;
            end else if (wr60 && a20_armed) begin
                a20_armed     <= 1'b0;
                // any other data byte after the command releases the mask
                addr20_mask_n <= io_wdata != mdpcb_pkg::A20_MASK_DATA;
            end
        end
    end

    // fast reset: delay then fixed-width pulse
    mdpcb_frst_e frst_q;
    logic [10:0] frst_cnt;
    logic        frst_cmd;
    assign frst_cmd = wr64 && r5b[mdpcb_pkg::FRST_EN_BIT] &&
                      io_wdata[7:4] == mdpcb_pkg::FRST_CMD_HIGH && !io_wdata[0];
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frst_q   <= MDPCB_IDLE;
            frst_cnt <= 11'h000;
        end else begin
            unique case (frst_q)
                MDPCB_IDLE: if (frst_cmd) begin
                    frst_q   <= MDPCB_DELAY;
                    frst_cnt <= r5b[mdpcb_pkg::FRST_LAT_BIT] ?
                                11'(mdpcb_pkg::FRST_LONG_CLK - 1) :
                                11'(mdpcb_pkg::FRST_SHORT_CLK - 1);
                end
                MDPCB_DELAY: if (frst_cnt == 11'h000) begin
                    frst_q   <= MDPCB_ASSERT;
                    frst_cnt <= 11'(mdpcb_pkg::RST_HOLD_CLKS - 1);
                end else begin
                    frst_cnt <= frst_cnt - 11'h001;
                end
                MDPCB_ASSERT: if (frst_cnt == 11'h000) begin
                    frst_q <= MDPCB_IDLE;
                end else begin
                    frst_cnt <= frst_cnt - 11'h001;
                end
            endcase
        end
    end
    assign processor_reset = frst_q == MDPCB_ASSERT;

    // refresh divider; a skipped tick while held is lost, not deferred
    logic [1:0] rfsh_div;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rfsh_div    <= 2'b00;
            refresh_req <= 1'b0;
        end else begin
            if (refresh_tick) begin
                rfsh_div <= rfsh_div + 2'b01;
            end
            refresh_req <= refresh_tick &&
                           (!r5b[mdpcb_pkg::SLOW_RFSH_BIT] || rfsh_div == 2'b11) &&
                           (!cpu_held || r5c[mdpcb_pkg::RFSH_HOLD_BIT]);
        end
    end

    // de-turbo window over a 12us frame
    logic [11:0] dt_cnt;
    logic        dt_active;
    assign dt_active = r5b[mdpcb_pkg::DT_SW_BIT] & deturbo_switch;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dt_cnt       <= 12'h000;
            cpu_hold_req <= 1'b0;
        end else begin
            if (!dt_active || dt_cnt == 12'(mdpcb_pkg::DT_PERIOD_CLK - 1)) begin
                dt_cnt <= 12'h000;
            end else begin
                dt_cnt <= dt_cnt + 12'h001;
            end
            cpu_hold_req <= dt_active && dt_cnt < (r5b[mdpcb_pkg::DT_HOLD_BIT] ?
                            12'(mdpcb_pkg::DT_LONG_CLK) : 12'(mdpcb_pkg::DT_SHORT_CLK));
        end
    end

    // delay lines for address strobe, target ready and full release
    logic [2:0] dly [3];
    logic [2:0] dly_in;
    assign dly_in = {full_released, trdy_seen, ~address_strobe_n};
    generate
        for (g = 0; g < 3; g++) begin : g_dly
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    dly[g] <= 3'b000;
                end else begin
                    dly[g] <= {dly[g][1:0], dly_in[g]};
                end
            end
        end
    endgenerate
    // tap k means k+1 clocks after the event
    assign local_status_sample = r5c[mdpcb_pkg::ADS_LAT_BIT] ? dly[0][1] : dly[0][2];
    assign burst_ready_n = !((r5d[mdpcb_pkg::TRDY_LAT_BIT] ? dly[1][2] : dly[1][1]) ||
                             (r5c[mdpcb_pkg::FULL_LAT_BIT] ? dly[2][1] : dly[2][0]));

    // pci clock enable by phase accumulation; reserved code stops it
    logic [9:0] pclk_acc, pclk_inc;
    logic [10:0] pclk_sum;
    always_comb begin
        unique case (r5d[7:6])
            2'b00:   pclk_inc = mdpcb_pkg::PCLK_INC_DIV2;
            2'b01:   pclk_inc = mdpcb_pkg::PCLK_INC_DIV15;
            2'b11:   pclk_inc = mdpcb_pkg::PCLK_INC_14M;
            default: pclk_inc = 10'h000;
        endcase
        pclk_sum = {1'b0, pclk_acc} + {1'b0, pclk_inc};
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pclk_acc     <= 10'h000;
            pci_clock_en <= 1'b0;
        end else begin
            pci_clock_en <= pclk_sum >= {1'b0, mdpcb_pkg::PCLK_MOD};
            pclk_acc     <= pclk_sum >= {1'b0, mdpcb_pkg::PCLK_MOD} ?
                            10'(pclk_sum - {1'b0, mdpcb_pkg::PCLK_MOD}) : pclk_sum[9:0];
        end
    end

    // standby event decode on the 10-bit i/o address
    logic disk_io, ser_io, par_io;
    logic [9:0] a;
    assign a = io_addr[9:0];
    assign disk_io = io_access && (a[9:3] == 7'h3e || a == 10'h3f6);
    assign ser_io  = io_access && (a[9:3] == 7'h5f || a[9:3] == 7'h7f ||
                                   a[9:3] == 7'h5d || a[9:3] == 7'h7d);
    assign par_io  = io_access && (a[9:3] == 7'h4f || a[9:3] == 7'h6f ||
                                   (a >= 10'h3bc && a <= 10'h3be));

    // event pulses and stop clock; a release wins over a same-cycle assert
    logic stp_release;
    assign stp_release = (irq_event & r5f[3]) | (hold_event & r5f[2]) |
                         (processor_init & r5f[1]);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sys_standby_reload <= 1'b0;
            monitor_reload     <= 1'b0;
            monitor_wake       <= 1'b0;
            stop_clock_n       <= 1'b1;
        end else begin
            sys_standby_reload <= (prog10_hit & r5e[7]) | (prog16_hit & r5e[6]) |
                                  (disk_io & r5e[5]) | (ser_io & r5e[4]) |
                                  (par_io & r5e[3]) | (hold_event & r5e[2]) |
                                  (irq_event & r5e[1]);
            monitor_reload <= (irq_event & r5f[7]) | (hold_event & r5f[6]);
            monitor_wake   <= (irq_event & r5f[5]) | (hold_event & r5f[4]);
            if (stp_release) begin
                stop_clock_n <= 1'b1;
            end else if (stop_clock_set) begin
                stop_clock_n <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    localparam int FR_LO = 401;
    property p_frst_hold;
        $rose(processor_reset) |-> processor_reset [*8] ##17 processor_reset ##1 !processor_reset;
    endproperty
    a_frst_hold: assert property (p_frst_hold) else $error("reset pulse width wrong");
    property p_frst_delay;
        (frst_cmd && frst_q == MDPCB_IDLE && !r5b[5]) |-> ##[FR_LO:FR_LO] $rose(processor_reset);
    endproperty
    a_frst_delay: assert property (p_frst_delay) else $error("reset delay wrong");
    property p_a20;
        (wr60 && a20_armed && io_wdata == 8'h00 && r5b[7]) |=> !addr20_mask_n;
    endproperty
    a_a20: assert property (p_a20) else $error("a20 mask not forced");
    property p_devsel; (wr64 || wr60) |=> devsel_slow == $past(r5b[7]); endproperty
    a_devsel: assert property (p_devsel) else $error("devsel claim wrong");
    property p_refresh;
        refresh_req |-> $past(refresh_tick) && (!$past(cpu_held) || $past(r5c[6]));
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh issued wrongly");
    property p_ads;
        (!address_strobe_n && !r5c[7] && $stable(r5c)) |-> ##3 local_status_sample;
    endproperty
    a_ads: assert property (p_ads) else $error("status sample late");
    property p_trdy; (trdy_seen && !r5d[2]) |-> ##2 !burst_ready_n; endproperty
    a_trdy: assert property (p_trdy) else $error("burst ready late");
    property p_stp; (irq_event && r5f[3]) |=> stop_clock_n; endproperty
    a_stp: assert property (p_stp) else $error("stop clock not released");
    property p_disk; (disk_io && r5e[5]) |=> sys_standby_reload; endproperty
    a_disk: assert property (p_disk) else $error("standby not reloaded");
    property p_pclk;
        (pci_clock_en && r5d[7:6] == 2'b00 && $stable(r5d)) |=> !pci_clock_en;
    endproperty
    a_pclk: assert property (p_pclk) else $error("pci clock too fast");
    c_frst: cover property ($rose(processor_reset));
    c_a20: cover property ($fell(addr20_mask_n));
    c_hold: cover property ($rose(cpu_hold_req));
endmodule // mdpcb_bank
`default_nettype wire

//--- tb/mdpcb_host_model.sv
// host i/o side model: issues single-cycle i/o writes toward the bank
`timescale 1ns/1ps
`default_nettype none
module mdpcb_host_model (
    input  wire logic        clock,
    output logic             io_wr,
    output logic             io_access,
    output logic      [15:0] io_addr,
    output logic      [7:0]  io_wdata
);
    // idle lines show the inverse of the last value so stale data never looks valid
    initial begin
        io_wr = 1'b0;
        io_access = 1'b0;
        io_addr = 16'hffff;
        io_wdata = 8'hff;
    end
    // one write pulse, launched and released on falling edges
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        io_wr = 1'b1;
        io_access = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge clock);
        io_wr = 1'b0;
        io_access = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask
endmodule // mdpcb_host_model
`default_nettype wire

//--- tb/mdpcb_bank_tb_top.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module mdpcb_bank_tb_top;
    logic        clock, rstn, cfg_wr, cfg_rd, push_rate_sel, refresh_tick, cpu_held;
    logic        deturbo_switch, address_strobe_n, trdy_seen, full_released, prog10_hit;
    logic        prog16_hit, hold_event, irq_event, processor_init, stop_clock_set;
    logic        shadow_hit, shadow_cacheable, uncached_hit, local_dram_off, devsel_slow;
    logic        addr20_mask_n, processor_reset, refresh_req, snoop_filter_en, cpu_hold_req;
    logic        local_status_sample, burst_ready_n, parity_check_en, pci_clock_en;
    logic        pci_post_en, pci_burst_en, sys_standby_reload, monitor_reload;
    logic        monitor_wake, stop_clock_n, io_wr, io_access;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, io_wdata;
    logic [1:0]  cache_burst_setting, post_push_rate;
    logic [15:0] io_addr;
    logic [31:0] host_addr;
    logic [10:0] burst_limit_bytes;
    int          errors, check_count, n, m;
    int          pclk_exp [4] = '{300, 400, 0, 42}; // enables per 600 cycles
    mdpcb_bank       i_dut (.*);
    mdpcb_host_model i_host (.clock(clock), .io_wr(io_wr), .io_access(io_access),
                             .io_addr(io_addr), .io_wdata(io_wdata));
    // free-running 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // value compare, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // register write, then one settling cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge clock);
        cfg_wr = 1'b0;
        @(negedge clock);
    endtask
    // register read and compare
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge clock);
        cfg_rd = 1'b0;
        @(negedge clock);
        chk(cfg_rdata, exp, "read");
    endtask
    // one-cycle event pulse
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {rstn, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, host_addr, push_rate_sel} = '0;
        {cache_burst_setting, refresh_tick, cpu_held, deturbo_switch, trdy_seen} = '0;
        {full_released, prog10_hit, prog16_hit, hold_event, irq_event} = '0;
        {processor_init, stop_clock_set, errors, check_count} = '0;
        address_strobe_n = 1'b1;
        repeat (12) @(posedge clock);
        @(negedge clock) rstn = 1'b1;
        for (int i = 0; i < 12; i++) rd(8'h54 + 8'(i), 8'h00);
        rd(8'h60, 8'h00);
        chk(parity_check_en, 1'b1, "parity");
        for (int i = 0; i < 12; i++) wr(8'h54 + 8'(i), 8'h25 ^ 8'(i));
        for (int i = 0; i < 12; i++) rd(8'h54 + 8'(i), 8'h25 ^ 8'(i));
        // 0x5c now holds 0x2d: parity off, snoop on, status 3T, full latency 2T
        chk(parity_check_en, 1'b0, "parity off");
        chk(snoop_filter_en, 1'b1, "snoop");
        wr(8'h54, 8'h44);
        host_addr = 32'h000e_4000;
        repeat (2) @(negedge clock);
        chk({shadow_hit, shadow_cacheable}, 2'b11, "shadow hit");
        host_addr = 32'h000e_0000;
        repeat (2) @(negedge clock);
        chk({shadow_hit, shadow_cacheable}, 2'b00, "shadow miss");
        wr(8'h57, 8'hc9);
        wr(8'h58, 8'h20);
        host_addr = 32'h0121_0000;
        repeat (2) @(negedge clock);
        chk({uncached_hit, local_dram_off}, 2'b11, "area hit");
        host_addr = 32'h0122_0000;
        repeat (2) @(negedge clock);
        chk(uncached_hit, 1'b0, "area miss");
        wr(8'h5b, 8'h80);
        i_host.io_write(16'h0064, 8'hd1);
        chk(devsel_slow, 1'b1, "claim");
        i_host.io_write(16'h0060, 8'h00);
        @(negedge clock);
        chk(addr20_mask_n, 1'b0, "a20 mask");
        for (int k = 0; k < 2; k++) begin
            wr(8'h5b, 8'h40 | 8'(k << 5));
            i_host.io_write(16'h0064, 8'hf6);
            chk(devsel_slow, 1'b0, "no claim");
            for (n = 1; processor_reset !== 1'b1 && n < 2000; n++) @(negedge clock);
            for (m = 0; processor_reset === 1'b1 && m < 100; m++) @(negedge clock);
            chk(n, 401 + 800 * k, "reset delay");
            chk(m, 25, "reset width");
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h5d, 8'h23 | 8'(k << 6));
            m = 0;
            repeat (600) @(negedge clock) m += int'(pci_clock_en === 1'b1);
            chk(m, pclk_exp[k], "pci clock");
        end
        chk(burst_limit_bytes, 11'd1024, "burst range");
        chk({pci_post_en, pci_burst_en}, 2'b11, "posting");
        wr(8'h5e, 8'h22);
        wr(8'h5f, 8'h88);
        i_host.io_write(16'h01f3, 8'h00);
        chk(sys_standby_reload, 1'b1, "disk");
        pulse(stop_clock_set);
        chk(stop_clock_n, 1'b0, "stop clock set");
        pulse(irq_event);
        chk({stop_clock_n, sys_standby_reload, monitor_reload, monitor_wake}, 4'b1110, "irq");
        wr(8'h5f, 8'h10);
        pulse(hold_event);
        chk({monitor_wake, sys_standby_reload}, 2'b10, "hold wake");
        @(negedge clock) address_strobe_n = 1'b0;
        @(negedge clock) address_strobe_n = 1'b1;
        repeat (2) @(negedge clock);
        chk(local_status_sample, 1'b1, "status sample");
        pulse(trdy_seen);
        @(negedge clock) chk(burst_ready_n, 1'b0, "trdy ready");
        pulse(full_released);
        @(negedge clock) chk(burst_ready_n, 1'b0, "full ready");
        cache_burst_setting = 2'b10;
        @(negedge clock) chk(post_push_rate, 2'b00, "push x111");
        push_rate_sel = 1'b1;
        @(negedge clock) chk(post_push_rate, 2'b10, "push set");
        deturbo_switch = 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(8'h5b, 8'(k * (k + 1)));
            m = 0;
            repeat (2400) @(negedge clock) m += int'(cpu_hold_req === 1'b1);
            chk(m, 800 * k, "de-turbo hold");
        end
        pulse(refresh_tick);
        chk(refresh_req, 1'b1, "refresh");
        cpu_held = 1'b1;
        pulse(refresh_tick);
        chk(refresh_req, 1'b0, "held refresh");
        {cpu_held, m} = '0;
        wr(8'h5b, 8'h10);
        repeat (4) begin
            pulse(refresh_tick);
            m += int'(refresh_req === 1'b1);
        end
        chk(m, 1, "slow refresh");
        print_verdict();
    end
endmodule // mdpcb_bank_tb_top
`default_nettype wire
